//--- hdl/mcr_pkg.sv
package mcr_pkg;
  // Pointer addresses (7-bit)
  localparam logic [6:0] MCR_A_MODE_ONE = 7'h0B;
  localparam logic [6:0] MCR_A_IPKTH    = 7'h15;
  localparam logic [6:0] MCR_A_VPKTH    = 7'h16;
  localparam logic [6:0] MCR_A_IPK      = 7'h17;
  localparam logic [6:0] MCR_A_IPK_CLR  = 7'h18;
  localparam logic [6:0] MCR_A_VPK      = 7'h19;
  localparam logic [6:0] MCR_A_VPK_CLR  = 7'h1A;
  localparam logic [6:0] MCR_A_GAIN     = 7'h1B;
  localparam logic [6:0] MCR_A_IBMATCH  = 7'h1C;
  localparam logic [6:0] MCR_A_ACT_GAIN = 7'h1D;
  localparam logic [6:0] MCR_A_RCT_GAIN = 7'h1E;
  localparam logic [6:0] MCR_A_APP_GAIN = 7'h1F;
  localparam logic [6:0] MCR_A_WOFS     = 7'h20;
  localparam logic [6:0] MCR_A_VAROFS   = 7'h21;
  localparam logic [6:0] MCR_A_IRMSOFS  = 7'h22;
  localparam logic [6:0] MCR_A_VRMSOFS  = 7'h23;
  localparam logic [6:0] MCR_A_WDIVR    = 7'h24;
  localparam logic [6:0] MCR_A_VARDIVR  = 7'h25;
  localparam logic [6:0] MCR_A_VADIVR   = 7'h26;
  localparam logic [6:0] MCR_A_P1NUM    = 7'h27;
  localparam logic [6:0] MCR_A_P2NUM    = 7'h29;
  localparam logic [6:0] MCR_A_P2DEN    = 7'h2A;
  localparam logic [6:0] MCR_A_ZXMODE   = 7'h2B;
  localparam logic [6:0] MCR_A_RSV_A    = 7'h3B;
  localparam logic [6:0] MCR_A_RSV_B    = 7'h3C;
  localparam logic [6:0] MCR_A_CAL_SEL  = 7'h3D;
  localparam logic [6:0] MCR_A_RSV_C    = 7'h3E;
  localparam logic [6:0] MCR_A_RSV_D    = 7'h3F;
  // Reset values
  localparam logic [7:0]  MCR_RST_MODE_ONE = 8'h06;
  localparam logic [15:0] MCR_RST_PKTH  = 16'hFFFF;
  localparam logic [15:0] MCR_RST_P2DEN = 16'h003F;
  localparam logic [15:0] MCR_RST_RSV_B = 16'h0300;
  // Mode one bit positions
  localparam int MCR_B_SOFTRST   = 7;
  localparam int MCR_B_ZXLPF_BYP = 6;
  localparam int MCR_B_INTEG     = 5;
  localparam int MCR_B_SWAP      = 4;
  localparam int MCR_B_CONV_OFF  = 3;
  localparam int MCR_B_P2DIS     = 2;
  localparam int MCR_B_P1DIS     = 1;
  localparam int MCR_B_HPF_BYP   = 0;
  // Byte lane select for the pointer data bytes
  typedef enum logic [1:0] {
    MCR_LANE_LOW,
    MCR_LANE_MID,
    MCR_LANE_HIGH
  } mcr_lane_t;
endpackage

//--- hdl/metering_calibration_regs.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Current peak threshold, 16 bits at 0x15, resets to all ones.
// - Voltage peak threshold, 16 bits at 0x16, resets to all ones.
// - Address 0x17 returns captured 24-bit current peak, no clear.
// - Address 0x18 returns current peak, then clears it to zero unless a capture lands that cycle.
// - Voltage peak readable at 0x19 plainly, 0x1A with clear.
// - Amplifier gain, 8 bits at 0x1B, resets to zero.
// - Second current matching gain, 12 bits signed at 0x1C.
// - Active, reactive, apparent gains, 12 bits at 0x1D to 0x1F.
// - Active and reactive power offsets, 16 bits at 0x20, 0x21.
// - Current and voltage rms offsets, 12 bits at 0x22, 0x23.
// - Energy dividers, 8 bits at 0x24, 0x25, 0x26, reset zero.
// - Pulse numerators at 0x27, 0x29; denominator 0x2A resets 0x003F.
// - Zero-cross output mode, 8 bits at 0x2B, resets zero.
// - Calibration mode select, 8 bits at 0x3D, resets zero.
// - Mode bit 7 written one restores all registers but the pointer address, write staging and read bytes to reset.
// - Mode bit 6 bypasses zero-cross low-pass filter.
// - Mode bit 5 inserts digital integrator in current path.
// - Mode bit 4 exchanges the two converter channel outputs.
// - Mode bit 3 powers down both converters.
// - Mode bits 2 and 1 disable second and first pulse outputs.
// - Mode bit 0 bypasses high-pass filters in both channels.
// - Core reaches registers via pointer address and low/mid/high bytes.
module mcr_metering_calibration_regs
  import mcr_pkg::*;
#(
  parameter int PEAK_W = 24
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        ptr_addr_wr,
  input  wire logic [7:0]  ptr_addr_wdata,
  input  wire logic        ptr_data_wr,
  input  wire logic [1:0]  ptr_data_lane,
  input  wire logic [7:0]  ptr_data_wdata,
  input  wire logic        ptr_rd,
  output logic      [7:0]  ptr_addr_rdata,
  output logic      [7:0]  metering_pointer_data_low,
  output logic      [7:0]  ptr_data_mid,
  output logic      [7:0]  ptr_data_high,
  input  wire logic        ipk_sample_vld,
  input  wire logic [23:0] ipk_sample,
  input  wire logic        vpk_sample_vld,
  input  wire logic [23:0] vpk_sample,
  output logic      [15:0] current_peak_threshold,
  output logic      [15:0] voltage_peak_threshold,
  output logic      [7:0]  input_amplifier_gain,
  output logic      [11:0] second_current_match_gain,
  output logic      [11:0] active_power_gain,
  output logic      [11:0] reactive_power_gain,
  output logic      [11:0] apparent_power_gain,
  output logic      [15:0] active_power_offset,
  output logic      [15:0] reactive_power_offset,
  output logic      [11:0] current_rms_offset,
  output logic      [11:0] voltage_rms_offset,
  output logic      [7:0]  active_energy_divider,
  output logic      [7:0]  reactive_energy_divider,
  output logic      [7:0]  apparent_energy_divider,
  output logic      [15:0] first_pulse_numerator,
  output logic      [15:0] second_pulse_numerator,
  output logic      [15:0] second_pulse_denominator,
  output logic      [7:0]  zero_cross_output_mode,
  output logic      [7:0]  calibration_mode_select,
  output logic             soft_reset_pulse,
  output logic             zero_cross_filter_bypass,
  output logic             integrator_enable,
  output logic             channel_exchange,
  output logic             converter_power_down,
  output logic             second_pulse_disable,
  output logic             first_pulse_disable,
  output logic             highpass_bypass
);

  if (PEAK_W != 24) begin : g_chk
    $error("PEAK_W must be 24");
  end

  logic [6:0]  metering_pointer_address;
  logic [7:0]  metering_mode_one;
  logic [7:0]  reserved_a;
  logic [15:0] reserved_b;
  logic [7:0]  reserved_c;
  logic [7:0]  reserved_d;
  logic [23:0] current_peak_value;
  logic [23:0] voltage_peak_value;
  logic [23:0] wr_shadow;
  logic [23:0] rd_value;
  logic [23:0] next_wr_word;
  logic        sw_rst;
  logic        wr_reg;
  logic        ipk_clr;
  logic        vpk_clr;
  logic        ipk_hit;
  logic        vpk_hit;

  // Write to a register lands on the low byte write; upper bytes staged
  function automatic logic [23:0] merge_lane(input logic [23:0] cur,
                                             input logic [1:0]  lane,
                                             input logic [7:0]  b);
    logic [23:0] r;
    r = cur;
    if (lane == MCR_LANE_LOW)
      r[7:0] = b;
    else if (lane == MCR_LANE_MID)
      r[15:8] = b;
    else
      r[23:16] = b;
    return r;
  endfunction

  // Low byte write commits the staged word to the addressed register
  assign next_wr_word = merge_lane(wr_shadow, ptr_data_lane, ptr_data_wdata);
  assign wr_reg   = ptr_data_wr && (ptr_data_lane == MCR_LANE_LOW);
  assign sw_rst   = wr_reg && (metering_pointer_address == MCR_A_MODE_ONE)
                    && next_wr_word[MCR_B_SOFTRST];
  assign ipk_clr  = ptr_rd && (metering_pointer_address == MCR_A_IPK_CLR);
  assign vpk_clr  = ptr_rd && (metering_pointer_address == MCR_A_VPK_CLR);
  assign ipk_hit  = ipk_sample_vld && (ipk_sample > current_peak_value)
                    && (ipk_sample[23:8] > current_peak_threshold);
  assign vpk_hit  = vpk_sample_vld && (vpk_sample > voltage_peak_value)
                    && (vpk_sample[23:8] > voltage_peak_threshold);

  // Pointer address and staging bytes
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      metering_pointer_address <= 7'h00;
      wr_shadow                <= 24'h000000;
    end else begin
      if (ptr_addr_wr)
        metering_pointer_address <= ptr_addr_wdata[6:0];
      if (ptr_data_wr && !wr_reg)
        wr_shadow <= next_wr_word;
    end
  end

  // Peak capture; a capture coincident with a clear is kept
  always_ff @(posedge core_clk) begin
    if (!rstn || sw_rst) begin
      current_peak_value <= 24'h000000;
      voltage_peak_value <= 24'h000000;
    end else begin
      if (ipk_hit && ipk_clr)
        current_peak_value <= ipk_sample;
      else if (ipk_hit)
        current_peak_value <= ipk_sample;
      else if (ipk_clr)
        current_peak_value <= 24'h000000;
      if (vpk_hit)
        voltage_peak_value <= vpk_sample;
      else if (vpk_clr)
        voltage_peak_value <= 24'h000000;
    end
  end

  // Configuration registers; soft reset restores them all
  always_ff @(posedge core_clk) begin
    if (!rstn || sw_rst) begin
      metering_mode_one         <= MCR_RST_MODE_ONE;
      current_peak_threshold    <= MCR_RST_PKTH;
      voltage_peak_threshold    <= MCR_RST_PKTH;
      input_amplifier_gain      <= 8'h00;
      second_current_match_gain <= 12'h000;
      active_power_gain         <= 12'h000;
      reactive_power_gain       <= 12'h000;
      apparent_power_gain       <= 12'h000;
      active_power_offset       <= 16'h0000;
      reactive_power_offset     <= 16'h0000;
      current_rms_offset        <= 12'h000;
      voltage_rms_offset        <= 12'h000;
      active_energy_divider     <= 8'h00;
      reactive_energy_divider   <= 8'h00;
      apparent_energy_divider   <= 8'h00;
      first_pulse_numerator     <= 16'h0000;
      second_pulse_numerator    <= 16'h0000;
      second_pulse_denominator  <= MCR_RST_P2DEN;
      zero_cross_output_mode    <= 8'h00;
      calibration_mode_select   <= 8'h00;
      reserved_a                <= 8'h00;
      reserved_b                <= MCR_RST_RSV_B;
      reserved_c                <= 8'h00;
      reserved_d                <= 8'h00;
    end else if (wr_reg) begin
      unique case (metering_pointer_address)
        MCR_A_MODE_ONE: metering_mode_one <= next_wr_word[7:0];
        MCR_A_IPKTH:   current_peak_threshold <= next_wr_word[15:0];
        MCR_A_VPKTH:   voltage_peak_threshold <= next_wr_word[15:0];
        MCR_A_GAIN:    input_amplifier_gain <= next_wr_word[7:0];
        MCR_A_IBMATCH: second_current_match_gain <= next_wr_word[11:0];
        MCR_A_ACT_GAIN: active_power_gain <= next_wr_word[11:0];
        MCR_A_RCT_GAIN: reactive_power_gain <= next_wr_word[11:0];
        MCR_A_APP_GAIN: apparent_power_gain <= next_wr_word[11:0];
        MCR_A_WOFS:    active_power_offset <= next_wr_word[15:0];
        MCR_A_VAROFS:  reactive_power_offset <= next_wr_word[15:0];
        MCR_A_IRMSOFS: current_rms_offset <= next_wr_word[11:0];
        MCR_A_VRMSOFS: voltage_rms_offset <= next_wr_word[11:0];
        MCR_A_WDIVR:   active_energy_divider <= next_wr_word[7:0];
        MCR_A_VARDIVR: reactive_energy_divider <= next_wr_word[7:0];
        MCR_A_VADIVR:  apparent_energy_divider <= next_wr_word[7:0];
        MCR_A_P1NUM:   first_pulse_numerator <= next_wr_word[15:0];
        MCR_A_P2NUM:   second_pulse_numerator <= next_wr_word[15:0];
        MCR_A_P2DEN:   second_pulse_denominator <= next_wr_word[15:0];
        MCR_A_ZXMODE:  zero_cross_output_mode <= next_wr_word[7:0];
        MCR_A_CAL_SEL: calibration_mode_select <= next_wr_word[7:0];
        MCR_A_RSV_A:   reserved_a <= next_wr_word[7:0];
        MCR_A_RSV_B:   reserved_b <= next_wr_word[15:0];
        MCR_A_RSV_C:   reserved_c <= next_wr_word[7:0];
        MCR_A_RSV_D:   reserved_d <= next_wr_word[7:0];
        default: ;
      endcase
    end
  end

  // matching gain written above
  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_value = 24'h000000;
    unique case (metering_pointer_address)
      MCR_A_MODE_ONE: rd_value = {16'h0000, metering_mode_one};
      MCR_A_IPKTH:   rd_value = {8'h00, current_peak_threshold};
      MCR_A_VPKTH:   rd_value = {8'h00, voltage_peak_threshold};
      MCR_A_IPK:     rd_value = current_peak_value;
      MCR_A_IPK_CLR: rd_value = current_peak_value;
      MCR_A_VPK:     rd_value = voltage_peak_value;
      MCR_A_VPK_CLR: rd_value = voltage_peak_value;
      MCR_A_GAIN:    rd_value = {16'h0000, input_amplifier_gain};
      MCR_A_IBMATCH: rd_value = {12'h000, second_current_match_gain};
      MCR_A_ACT_GAIN: rd_value = {12'h000, active_power_gain};
      MCR_A_RCT_GAIN: rd_value = {12'h000, reactive_power_gain};
      MCR_A_APP_GAIN: rd_value = {12'h000, apparent_power_gain};
      MCR_A_WOFS:    rd_value = {8'h00, active_power_offset};
      MCR_A_VAROFS:  rd_value = {8'h00, reactive_power_offset};
      MCR_A_IRMSOFS: rd_value = {12'h000, current_rms_offset};
      MCR_A_VRMSOFS: rd_value = {12'h000, voltage_rms_offset};
      MCR_A_WDIVR:   rd_value = {16'h0000, active_energy_divider};
      MCR_A_VARDIVR: rd_value = {16'h0000, reactive_energy_divider};
      MCR_A_VADIVR:  rd_value = {16'h0000, apparent_energy_divider};
      MCR_A_P1NUM:   rd_value = {8'h00, first_pulse_numerator};
      MCR_A_P2NUM:   rd_value = {8'h00, second_pulse_numerator};
      MCR_A_P2DEN:   rd_value = {8'h00, second_pulse_denominator};
      MCR_A_ZXMODE:  rd_value = {16'h0000, zero_cross_output_mode};
      MCR_A_CAL_SEL: rd_value = {16'h0000, calibration_mode_select};
      MCR_A_RSV_A:   rd_value = {16'h0000, reserved_a};
      MCR_A_RSV_B:   rd_value = {8'h00, reserved_b};
      MCR_A_RSV_C:   rd_value = {16'h0000, reserved_c};
      MCR_A_RSV_D:   rd_value = {16'h0000, reserved_d};
      default:       rd_value = 24'h000000;
    endcase
  end

  // Read latch: bytes show the value held before any clear
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      metering_pointer_data_low <= 8'h00;
      ptr_data_mid              <= 8'h00;
      ptr_data_high             <= 8'h00;
    end else if (ptr_rd) begin
      metering_pointer_data_low <= rd_value[7:0];
      ptr_data_mid              <= rd_value[15:8];
      ptr_data_high             <= rd_value[23:16];
    end
  end

  // Pointer address readback and mode one control outputs
  assign ptr_addr_rdata           = {1'b0, metering_pointer_address};
  assign soft_reset_pulse         = sw_rst;
  assign zero_cross_filter_bypass = metering_mode_one[MCR_B_ZXLPF_BYP];
  assign integrator_enable        = metering_mode_one[MCR_B_INTEG];
  assign channel_exchange         = metering_mode_one[MCR_B_SWAP];
  assign converter_power_down     = metering_mode_one[MCR_B_CONV_OFF];
  assign second_pulse_disable     = metering_mode_one[MCR_B_P2DIS];
  assign first_pulse_disable      = metering_mode_one[MCR_B_P1DIS];
  assign highpass_bypass          = metering_mode_one[MCR_B_HPF_BYP];

endmodule
`default_nettype wire

//--- sim/mcr_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_regs_checker (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        ptr_addr_wr,
  input wire logic [7:0]  ptr_addr_wdata,
  input wire logic        ptr_data_wr,
  input wire logic [1:0]  ptr_data_lane,
  input wire logic [7:0]  ptr_data_wdata,
  input wire logic        ptr_rd,
  input wire logic [7:0]  ptr_addr_rdata,
  input wire logic [7:0]  metering_pointer_data_low,
  input wire logic [7:0]  ptr_data_mid,
  input wire logic [7:0]  ptr_data_high,
  input wire logic        ipk_sample_vld,
  input wire logic [15:0] current_peak_threshold,
  input wire logic [15:0] voltage_peak_threshold,
  input wire logic [15:0] second_pulse_denominator,
  input wire logic        zero_cross_filter_bypass,
  input wire logic        integrator_enable,
  input wire logic        channel_exchange,
  input wire logic        converter_power_down,
  input wire logic        second_pulse_disable,
  input wire logic        first_pulse_disable,
  input wire logic        highpass_bypass
);
  // Read bytes, pointer and mode write decode
  wire logic [23:0] rd_bytes = {ptr_data_high, ptr_data_mid,
                                metering_pointer_data_low};
  wire logic [6:0]  ptr      = ptr_addr_rdata[6:0];
  wire logic        mode_wr  = ptr_data_wr && ptr_data_lane == 2'h0 &&
                               ptr == 7'h0B;
  wire logic [6:0]  mode_bits = {zero_cross_filter_bypass, integrator_enable,
    channel_exchange, converter_power_down, second_pulse_disable,
    first_pulse_disable, highpass_bypass};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_ADDR_ECHO: assert property (
    ptr_addr_wr |=> ptr_addr_rdata == ($past(ptr_addr_wdata) & 8'h7F))
    else $error("pointer address not taken");
  AST_RD_THR: assert property (
    ptr_rd && ptr == 7'h15 |=>
      rd_bytes == {8'h00, $past(current_peak_threshold)})
    else $error("threshold read bytes wrong");
  AST_CLR_READ: assert property (
    (ptr_rd && ptr == 7'h18 && !ipk_sample_vld) ##1 (!ipk_sample_vld)[*4]
      ##0 (ptr_rd && ptr == 7'h17) |=> rd_bytes == 24'h000000)
    else $error("current peak not cleared by clearing read");
  AST_UNMAPPED: assert property (
    ptr_rd && (ptr == 7'h28 || ptr[6]) |=> rd_bytes == 24'h000000)
    else $error("unmapped read not zero");
  AST_RD_STANDS: assert property (
    !ptr_rd |=> $stable(rd_bytes))
    else $error("read bytes moved without a read");
  AST_VTH_HOLD: assert property (
    !ptr_data_wr |=> $stable(voltage_peak_threshold))
    else $error("voltage threshold moved without a write");
  AST_MODE_BITS: assert property (
    mode_wr && !ptr_data_wdata[7] |=>
      {1'b0, mode_bits} == ($past(ptr_data_wdata) & 8'h7F))
    else $error("mode bit outputs differ from written byte");
  AST_SOFT_RESET: assert property (
    mode_wr && ptr_data_wdata[7] |=> mode_bits == 7'h06 &&
      current_peak_threshold == 16'hFFFF &&
      second_pulse_denominator == 16'h003F)
    else $error("soft reset left a register off its reset value");
endmodule
bind mcr_metering_calibration_regs mcr_regs_checker CHK (
  .core_clk(core_clk), .rstn(rstn), .ptr_addr_wr(ptr_addr_wr),
  .ptr_addr_wdata(ptr_addr_wdata), .ptr_data_wr(ptr_data_wr),
  .ptr_data_lane(ptr_data_lane), .ptr_data_wdata(ptr_data_wdata),
  .ptr_rd(ptr_rd), .ptr_addr_rdata(ptr_addr_rdata),
  .metering_pointer_data_low(metering_pointer_data_low),
  .ptr_data_mid(ptr_data_mid), .ptr_data_high(ptr_data_high),
  .ipk_sample_vld(ipk_sample_vld),
  .current_peak_threshold(current_peak_threshold),
  .voltage_peak_threshold(voltage_peak_threshold),
  .second_pulse_denominator(second_pulse_denominator),
  .zero_cross_filter_bypass(zero_cross_filter_bypass),
  .integrator_enable(integrator_enable),
  .channel_exchange(channel_exchange),
  .converter_power_down(converter_power_down),
  .second_pulse_disable(second_pulse_disable),
  .first_pulse_disable(first_pulse_disable),
  .highpass_bypass(highpass_bypass));
`default_nettype wire

//--- sim/mcr_peak_feed.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_peak_feed (
  input  wire logic        core_clk,
  output logic             ipk_sample_vld,
  output logic      [23:0] ipk_sample,
  output logic             vpk_sample_vld,
  output logic      [23:0] vpk_sample
);
  // Idle strobes low, sample lines hold junk
  initial begin
    ipk_sample_vld = 1'b0;
    vpk_sample_vld = 1'b0;
    ipk_sample = 24'hA5A5A5;
    vpk_sample = 24'h5A5A5A;
  end
  // One-cycle sample strobe, then lines go stale
  task automatic push(input logic sel, input logic [23:0] val);
    @(posedge core_clk);
    if (sel) begin
      vpk_sample_vld <= 1'b1;
      vpk_sample <= val;
    end else begin
      ipk_sample_vld <= 1'b1;
      ipk_sample <= val;
    end
    @(posedge core_clk);
    ipk_sample_vld <= 1'b0;
    vpk_sample_vld <= 1'b0;
    ipk_sample <= ~val;
    vpk_sample <= ~val;
  endtask
endmodule
`default_nettype wire

//--- sim/metering_calibration_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module metering_calibration_regs_tb;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ptr_addr_wr = 1'b0;
  logic [7:0]  ptr_addr_wdata = 8'h00;
  logic        ptr_data_wr = 1'b0;
  logic [1:0]  ptr_data_lane = 2'h0;
  logic [7:0]  ptr_data_wdata = 8'h00;
  logic        ptr_rd = 1'b0;
  logic        ipk_vld, vpk_vld;
  logic [23:0] ipk_smp, vpk_smp, v;
  wire logic [23:0] rd_bytes;
  wire logic [6:0]  mode_bits;
  int n_mismatch = 0;
  int n_tests = 0;
  localparam logic [6:0] RW_A [20] = '{7'h0B, 7'h15, 7'h16, 7'h1B, 7'h1C,
    7'h1D, 7'h1E, 7'h1F, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26,
    7'h27, 7'h29, 7'h2A, 7'h2B, 7'h3D};
  localparam int RW_W [20] = '{8, 16, 16, 8, 12, 12, 12, 12, 16, 16, 12,
    12, 8, 8, 8, 16, 16, 16, 8, 8};
  localparam logic [6:0] RO_A [8] = '{7'h17, 7'h19, 7'h3B, 7'h3C, 7'h3E,
    7'h3F, 7'h28, 7'h50};
  mcr_metering_calibration_regs DUT (
    .core_clk(core_clk), .rstn(rstn), .ptr_addr_wr(ptr_addr_wr),
    .ptr_addr_wdata(ptr_addr_wdata), .ptr_data_wr(ptr_data_wr),
    .ptr_data_lane(ptr_data_lane), .ptr_data_wdata(ptr_data_wdata),
    .ptr_rd(ptr_rd), .ptr_addr_rdata(),
    .metering_pointer_data_low(rd_bytes[7:0]),
    .ptr_data_mid(rd_bytes[15:8]), .ptr_data_high(rd_bytes[23:16]),
    .ipk_sample_vld(ipk_vld), .ipk_sample(ipk_smp),
    .vpk_sample_vld(vpk_vld), .vpk_sample(vpk_smp),
    .current_peak_threshold(), .voltage_peak_threshold(),
    .input_amplifier_gain(), .second_current_match_gain(),
    .active_power_gain(), .reactive_power_gain(), .apparent_power_gain(),
    .active_power_offset(), .reactive_power_offset(),
    .current_rms_offset(), .voltage_rms_offset(), .active_energy_divider(),
    .reactive_energy_divider(), .apparent_energy_divider(),
    .first_pulse_numerator(), .second_pulse_numerator(),
    .second_pulse_denominator(), .zero_cross_output_mode(),
    .calibration_mode_select(), .soft_reset_pulse(),
    .zero_cross_filter_bypass(mode_bits[6]),
    .integrator_enable(mode_bits[5]), .channel_exchange(mode_bits[4]),
    .converter_power_down(mode_bits[3]),
    .second_pulse_disable(mode_bits[2]),
    .first_pulse_disable(mode_bits[1]), .highpass_bypass(mode_bits[0]));
  mcr_peak_feed FEED (.core_clk(core_clk), .ipk_sample_vld(ipk_vld),
    .ipk_sample(ipk_smp), .vpk_sample_vld(vpk_vld), .vpk_sample(vpk_smp));
  // 50 MHz clock
  always #10 core_clk = ~core_clk;
  // Reset values of the bank
  function automatic logic [23:0] rst_of(input logic [6:0] a);
    case (a)
      7'h0B: rst_of = 24'h000006;
      7'h15, 7'h16: rst_of = 24'h00FFFF;
      7'h2A: rst_of = 24'h00003F;
      7'h3C: rst_of = 24'h000300;
      default: rst_of = 24'h000000;
    endcase
  endfunction
  task automatic check(input string nm, input logic [23:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Pointer write, then high, mid and finally committing low byte
  task automatic wr_reg(input logic [6:0] a, input logic [23:0] d);
    @(posedge core_clk);
    ptr_addr_wr <= 1'b1;
    ptr_addr_wdata <= {1'b0, a};
    @(posedge core_clk);
    ptr_addr_wr <= 1'b0;
    ptr_data_wr <= 1'b1;
    ptr_data_lane <= 2'h2;
    ptr_data_wdata <= d[23:16];
    @(posedge core_clk);
    ptr_data_lane <= 2'h1;
    ptr_data_wdata <= d[15:8];
    @(posedge core_clk);
    ptr_data_lane <= 2'h0;
    ptr_data_wdata <= d[7:0];
    @(posedge core_clk);
    ptr_data_wr <= 1'b0;
  endtask
  // Pointer write, read strobe, bytes taken a cycle later
  task automatic rd_reg(input logic [6:0] a, output logic [23:0] d);
    @(posedge core_clk);
    ptr_addr_wr <= 1'b1;
    ptr_addr_wdata <= {1'b0, a};
    @(posedge core_clk);
    ptr_addr_wr <= 1'b0;
    ptr_rd <= 1'b1;
    @(posedge core_clk);
    ptr_rd <= 1'b0;
    @(posedge core_clk);
    #1 d = rd_bytes;
  endtask
  // Reset or pattern readback of the whole bank
  task automatic sweep(input logic wr);
    logic [23:0] p;
    for (int i = 0; i < 20; i++) begin
      p = (24'hA5C35A ^ 24'(i)) & ((24'h000001 << RW_W[i]) - 24'h000001);
      if (wr) wr_reg(RW_A[i], p);
      rd_reg(RW_A[i], v);
      check("rw reg", v, wr ? p : rst_of(RW_A[i]));
    end
    for (int i = 0; i < 8; i++) begin
      if (wr && (i == 0 || i > 5)) wr_reg(RO_A[i], 24'hFFFFFF);
      rd_reg(RO_A[i], v);
      check("ro reg", v, rst_of(RO_A[i]));
    end
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    sweep(1'b0);
    sweep(1'b1);
    check("mode out", {17'h0, mode_bits}, 24'h00005A);
    wr_reg(7'h0B, 24'h000025);
    rd_reg(7'h0B, v);
    check("mode out", {17'h0, mode_bits}, 24'h000025);
    wr_reg(7'h0B, 24'h000080);
    sweep(1'b0);
    wr_reg(7'h15, 24'h000010);
    wr_reg(7'h16, 24'h000001);
    FEED.push(1'b0, 24'h001234);
    FEED.push(1'b0, 24'h000F99);
    FEED.push(1'b0, 24'h001100);
    rd_reg(7'h17, v);
    check("current_peak_value", v, 24'h001234);
    rd_reg(7'h17, v);
    check("current_peak_value", v, 24'h001234);
    rd_reg(7'h18, v);
    check("current_peak_value clr", v, 24'h001234);
    rd_reg(7'h17, v);
    check("current_peak_value", v, 24'h000000);
    FEED.push(1'b1, 24'h00ABCD);
    fork
      rd_reg(7'h1A, v);
      begin
        @(posedge core_clk);
        FEED.push(1'b1, 24'h00EEEE);
      end
    join
    check("voltage_peak_value clr", v, 24'h00ABCD);
    rd_reg(7'h19, v);
    check("voltage_peak_value", v, 24'h00EEEE);
    conclude;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    conclude;
  end
endmodule
`default_nettype wire
